// >>> bench/fpbx_exchange_asserts.sv
// Port checks for the exchange block
`timescale 1ns/1ps
module fpbx_exchange_asserts (
  // Clock and reset
  input wire logic                    clk,
  input wire logic                    reset,
  // Bus and library side
  input wire fpbx_pkg::fpbx_axi_req_t axiReq,
  input wire fpbx_pkg::fpbx_axi_rsp_t axiRsp,
  input wire logic                    commitPulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Answers stand until the master takes them
  chk_bresp_holds: assert property (axiRsp.bvalid && !axiReq.bready
    |=> axiRsp.bvalid && $stable(axiRsp.bresp)) else $error("write answer dropped");
  chk_rdata_holds: assert property (axiRsp.rvalid && !axiReq.rready
    |=> axiRsp.rvalid && $stable(axiRsp.rdata)) else $error("read answer dropped");
  chk_read_answer: assert property (axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid)
    else $error("read not answered next cycle");
  // One operation at a time per direction; legal response codes, no data on error reads
  chk_one_read: assert property (axiRsp.rvalid |-> !axiRsp.arready)
    else $error("read taken while answer pending");
  chk_one_write: assert property (axiRsp.bvalid |-> !axiRsp.awready && !axiRsp.wready)
    else $error("write taken while answer pending");
  chk_bresp_code: assert property (axiRsp.bvalid |-> axiRsp.bresp inside {2'h0, 2'h2})
    else $error("bad write response code");
  chk_err_zero: assert property (axiRsp.rvalid && axiRsp.rresp == 2'h2
    |-> axiRsp.rdata == 32'h0) else $error("error read carries data");
  // Commit is a single pulse per finished set
  chk_commit_single: assert property (commitPulse |=> !commitPulse)
    else $error("commit pulse too long");
  cover property (commitPulse);
  cover property (axiRsp.rvalid && axiRsp.rresp == 2'h2);
  cover property (axiRsp.rvalid && axiReq.rready);
endmodule
bind fpbx_exchange fpbx_exchange_asserts u_chk (.clk(clk), .reset(reset), .axiReq(axiReq),
  .axiRsp(axiRsp), .commitPulse(commitPulse));

// >>> bench/fpbx_exchange_tb.sv
// Self-checking bench for the fusion parameter block exchange
`timescale 1ns/1ps
module fpbx_exchange_tb;
  logic clk, reset, commit;
  fpbx_pkg::fpbx_axi_req_t rq;
  fpbx_pkg::fpbx_axi_rsp_t rs;
  fpbx_pkg::fpbx_version_t ver;
  fpbx_pkg::fpbx_vinfo_t   rec;
  logic [7:0]  qid, id, st[$], b[72], rData;
  logic [1:0]  cSet, rp, rSet;
  logic [6:0]  rAddr;
  logic [31:0] d, s, e[8], bad[3];
  int          err_total, n_compared, cyc, nCommit;
  fpbx_exchange dut (.clk(clk), .reset(reset), .axiReq(rq), .axiRsp(rs), .libVersion(ver),
    .infoRec(rec), .infoQueryId(qid), .libWr('0), .stateRdSet(rSet), .stateRdAddr(rAddr),
    .stateRdData(rData), .commitPulse(commit), .commitSet(cSet));
  fpbx_lib_model lib (.infoQueryId(qid), .libVersion(ver), .infoRec(rec));
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  // Hang guard and commit counter
  always @(posedge clk) begin
    cyc++;
    if (commit) nCommit++;
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end
  task automatic end_sim();
    if (err_total == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  // Address and data offered together, each released when taken
  task automatic axW(input logic [7:0] a, input logic [31:0] v);
    bit aw, w;
    @(posedge clk);
    rq.awaddr <= a; rq.awvalid <= 1; rq.wdata <= v; rq.wstrb <= 4'hf;
    rq.wvalid <= 1; rq.bready <= 1;
    while (!(aw && w)) begin
      @(posedge clk);
      if (rs.awready && rq.awvalid) begin aw = 1; rq.awvalid <= 0; end
      if (rs.wready && rq.wvalid) begin w = 1; rq.wvalid <= 0; end
    end
    do @(posedge clk); while (rs.bvalid !== 1'b1);
    rq.bready <= 0;
  endtask
  task automatic axR(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    rq.araddr <= a; rq.arvalid <= 1; rq.rready <= 1;
    do @(posedge clk); while (rs.arready !== 1'b1);
    rq.arvalid <= 0;
    do @(posedge clk); while (rs.rvalid !== 1'b1);
    v = rs.rdata; rp = rs.rresp; rq.rready <= 0;
  endtask
  // Poll until idle with done or error, since busy may lag the write
  task automatic cmd(input logic [31:0] v);
    axW(fpbx_pkg::ADDR_CTRL, v);
    do axR(fpbx_pkg::ADDR_STATUS, s); while (s[0] !== 1'b0 || !(s[1] | s[2]));
  endtask
  // Bench model of one exchange block
  task automatic mk(input logic [15:0] p, input logic [7:0] inf, bl, input logic [15:0] t,
                    input int base);
    {b[1], b[0]} = p; {b[3], b[2]} = 16'h0044; b[4] = inf; b[5] = bl; {b[7], b[6]} = t;
    for (int k = 0; k < 64; k++) b[8+k] = (k < bl) ? st[base+k] : 8'h00;
  endtask
  task automatic bufIo(input bit rd);
    for (int i = 0; i < 18; i++)
      if (rd) begin
        axR(8'(fpbx_pkg::ADDR_BUF_BASE + 4*i), d);
        chk("block", d, {b[4*i+3], b[4*i+2], b[4*i+1], b[4*i]});
      end else axW(8'(fpbx_pkg::ADDR_BUF_BASE + 4*i), {b[4*i+3], b[4*i+2], b[4*i+1], b[4*i]});
  endtask
  initial begin
    rq = '0; reset = 1; rSet = 2'h0; rAddr = 7'h00;
    bad = '{32'h0000027d, 32'h0001027e, 32'h00010301};
    void'($urandom(64767));
    repeat (4) @(posedge clk);
    reset <= 0;
    cmd(32'h0000027e);
    axR(8'h40, d); chk("ver hdr", d, 32'h0004027e);
    axR(8'h44, d); chk("ver", d, 32'h02070103);
    // Supported first id, unsupported last id
    for (int j = 0; j < 2; j++) begin
      id = j ? 8'h95 : 8'h01;
      e = '{default: 32'h0};
      e[0] = {16'h001c, 8'h03, id};
      if (id <= 8'h10) begin
        e[1] = {8'h0c, 8'h02, id ^ 8'h5a, id}; e[2] = 32'h07d0;
        e[6] = 32'h80000000; e[7] = 32'h3f;
      end
      cmd({16'h0, 8'h03, id});
      for (int i = 0; i < 8; i++) begin
        axR(8'(8'h40 + 4*i), d); chk("record", d, e[i]);
      end
    end
    repeat (100) st.push_back(8'($urandom));
    // Restore accel in two blocks, later save it back; lone non-final gyro block
    mk(16'h0201, 8'h00, 8'd64, 16'd100, 0); bufIo(0); cmd(32'h00010201);
    mk(16'h0201, 8'h81, 8'd36, 16'd100, 64); bufIo(0); cmd(32'h00010201);
    chk("commits", nCommit, 1);
    chk("commit set", cSet, 2'h0);
    mk(16'h0203, 8'h00, 8'd64, 16'd100, 0); bufIo(0); cmd(32'h00010203);
    mk(16'h0201, 8'h00, 8'd64, 16'd100, 0); cmd(32'h00000201); bufIo(1);
    mk(16'h0201, 8'h81, 8'd36, 16'd100, 64); cmd(32'h00000201); bufIo(1);
    mk(16'h0203, 8'h80, 8'd0, 16'd0, 0); cmd(32'h00000203); bufIo(1);
    chk("commits", nCommit, 1);
    // Active accel holds the restored bytes, half-written gyro stays empty
    for (int k = 0; k < 100; k++) begin
      @(posedge clk); rSet <= 2'h0; rAddr <= 7'(k);
      @(posedge clk); rSet <= 2'h1;
      @(posedge clk); chk("active", rData, st[k]);
      @(posedge clk); chk("staged", rData, 8'h00);
    end
    // Soft-iron matrix in one final block becomes active at once
    mk(16'h027d, 8'h80, 8'd20, 16'd20, 0); bufIo(0); cmd(32'h0001027d);
    chk("commits", nCommit, 2);
    chk("commit set", cSet, 2'h3);
    foreach (bad[i]) begin
      cmd(bad[i]); chk("error", s[2], 1'b1);
    end
    axR(8'h10, d); chk("unmapped", rp, fpbx_pkg::RESP_SLVERR);
    end_sim();
  end
endmodule

// >>> bench/fpbx_lib_model.sv
// Fusion library stand-in: version and virtual sensor records
`timescale 1ns/1ps
module fpbx_lib_model (
  // Query
  input  wire logic [7:0]              infoQueryId,
  // Answers
  output      fpbx_pkg::fpbx_version_t libVersion,
  output      fpbx_pkg::fpbx_vinfo_t   infoRec
);
  // Version bytes are arbitrary
  assign libVersion = '{8'h03, 8'h01, 8'h07, 8'h02};
  // Ids 1..16 supported; driver id derived from id so ids differ
  always_comb begin
    infoRec = '0;
    if (infoQueryId != 8'h00 && infoQueryId <= 8'h10) begin
      infoRec.supported = 1'b1;
      infoRec.driverId = infoQueryId ^ 8'h5a;
      infoRec.driverVer = 8'h02;
      infoRec.power = 8'h0c;
      infoRec.maxRange = 16'h07d0;
      infoRec.minRate = 32'h3f800000;
    end
  end
endmodule

// >>> logic/fpbx_exchange.sv
// Fusion parameter block exchange: AXI4-Lite command port and state store
//
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps

module fpbx_exchange (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     reset,
  // AXI4-Lite register port
  input  wire fpbx_pkg::fpbx_axi_req_t  axiReq,
  output      fpbx_pkg::fpbx_axi_rsp_t  axiRsp,
  // Fusion library facing side
  input  wire fpbx_pkg::fpbx_version_t  libVersion,
  input  wire fpbx_pkg::fpbx_vinfo_t    infoRec,
  output      logic [7:0]               infoQueryId,
  input  wire fpbx_pkg::fpbx_lib_wr_t   libWr,
  input  wire logic [1:0]               stateRdSet,
  input  wire logic [6:0]               stateRdAddr,
  output      logic [7:0]               stateRdData,
  output      logic                     commitPulse,
  output      logic [1:0]               commitSet
);

  typedef struct packed {
    fpbx_pkg::fpbx_fsm_t                          fsm;
    logic                                         awHeld;
    logic [7:0]                                   awAddr;
    logic                                         wHeld;
    logic [31:0]                                  wData;
    logic [3:0]                                   wStrb;
    logic                                         bValid;
    logic [1:0]                                   bResp;
    logic                                         rValid;
    logic [31:0]                                  rData;
    logic [1:0]                                   rResp;
    logic [15:0]                                  param;
    logic                                         isSet;
    logic                                         busy;
    logic                                         done;
    logic                                         err;
    logic [1:0]                                   curSet;
    logic [6:0]                                   curBlk;
    logic                                         curFin;
    logic [7:0]                                   curLen;
    logic [5:0]                                   idx;
    logic [6:0]                                   rdBlk;
    logic [1:0]                                   rdSet;
    logic [6:0]                                   stageNext;
    logic [1:0]                                   stageSet;
    logic [15:0]                                  stageLen;
    logic [7:0]                                   infoId;
    logic                                         commit;
    logic [7:0]                                   rdOut;
    logic [fpbx_pkg::BUF_BYTES-1:0][7:0]          xbuf;
    logic [fpbx_pkg::STATE_BYTES-1:0][7:0]        stage;
    logic [3:0][fpbx_pkg::STATE_BYTES-1:0][7:0]   sets;
    logic [3:0][15:0]                             setLen;
  } fpbx_state_t;

  fpbx_state_t s;
  fpbx_state_t next_s;

  logic       awFire;
  logic       wFire;
  logic       arFire;
  logic [4:0] rdWord;
  logic [4:0] wrWord;
  logic [2:0] calDec;
  logic [6:0] pos;
  logic [15:0] hdrLen;
  logic [7:0]  hdrBlkLen;
  logic [15:0] hdrTot;
  logic [6:0]  hdrBlk;
  logic        hdrFin;
  logic [15:0] remain;

  // Maps a state parameter number to {valid, set index}
  function automatic logic [2:0] paramSet(input logic [15:0] p);
    logic [15:0] inputId;
    inputId = p - fpbx_pkg::PARAM_CAL_BASE;
    paramSet = 3'h0;
    if (p == fpbx_pkg::PARAM_SOFT_IRON) begin
      paramSet = {1'b1, fpbx_pkg::SET_SOFTIRON};
    end else if (p >= fpbx_pkg::PARAM_CAL_FIRST && p <= fpbx_pkg::PARAM_CAL_LAST) begin
      case (inputId[7:0])
        fpbx_pkg::INPUT_ACCEL: paramSet = {1'b1, fpbx_pkg::SET_ACCEL};
        fpbx_pkg::INPUT_GYRO:  paramSet = {1'b1, fpbx_pkg::SET_GYRO};
        fpbx_pkg::INPUT_MAG:   paramSet = {1'b1, fpbx_pkg::SET_MAG};
        default:               paramSet = 3'h0;
      endcase
    end
  endfunction

  // Buffer word index of a register address, 5'h1f when outside the window
  function automatic logic [4:0] bufWord(input logic [7:0] a);
    logic [7:0] rel;
    rel = a - fpbx_pkg::ADDR_BUF_BASE;
    bufWord = 5'h1f;
    if (a >= fpbx_pkg::ADDR_BUF_BASE && rel[7:2] < 6'(fpbx_pkg::BUF_WORDS)) begin
      bufWord = rel[6:2];
    end
  endfunction

  // Bus handshakes; write side stalls while a response is pending
  assign awFire = axiReq.awvalid && !s.awHeld && !s.bValid;
  assign wFire  = axiReq.wvalid && !s.wHeld && !s.bValid;
  assign arFire = axiReq.arvalid && !s.rValid;
  assign rdWord = bufWord(axiReq.araddr);
  assign wrWord = bufWord(s.awAddr);
  assign calDec = paramSet(s.wData[15:0]);

  // Incoming block header fields, little endian
  assign hdrLen    = {s.xbuf[fpbx_pkg::OFS_LEN + 1], s.xbuf[fpbx_pkg::OFS_LEN]};
  assign hdrBlk    = s.xbuf[fpbx_pkg::OFS_BLKINFO][6:0];
  assign hdrFin    = s.xbuf[fpbx_pkg::OFS_BLKINFO][7];
  assign hdrBlkLen = s.xbuf[fpbx_pkg::OFS_BLKLEN];
  assign hdrTot    = {s.xbuf[fpbx_pkg::OFS_TOTLEN + 1], s.xbuf[fpbx_pkg::OFS_TOTLEN]};
  assign remain    = s.setLen[calDec[1:0]] - {3'h0, s.rdBlk, 6'h00};
  assign pos       = {s.curBlk[0], s.idx};

  always_comb begin
    next_s = s;
    next_s.commit = 1'b0;
    next_s.rdOut = s.sets[stateRdSet][stateRdAddr];

    // Address and data latch independently, in either order
    if (awFire) begin
      next_s.awHeld = 1'b1;
      next_s.awAddr = axiReq.awaddr;
    end
    if (wFire) begin
      next_s.wHeld = 1'b1;
      next_s.wData = axiReq.wdata;
      next_s.wStrb = axiReq.wstrb;
    end
    if (s.bValid && axiReq.bready) begin
      next_s.bValid = 1'b0;
    end
    if (s.rValid && axiReq.rready) begin
      next_s.rValid = 1'b0;
    end

    // Register read, answered one cycle after the address is taken
    if (arFire) begin
      next_s.rValid = 1'b1;
      next_s.rResp = fpbx_pkg::RESP_OKAY;
      next_s.rData = 32'h0;
      if (axiReq.araddr == fpbx_pkg::ADDR_CTRL) begin
        next_s.rData = {15'h0, s.isSet, s.param};
      end else if (axiReq.araddr == fpbx_pkg::ADDR_STATUS) begin
        next_s.rData[fpbx_pkg::STAT_BUSY_BIT] = s.busy;
        next_s.rData[fpbx_pkg::STAT_DONE_BIT] = s.done;
        next_s.rData[fpbx_pkg::STAT_ERR_BIT]  = s.err;
      end else if (axiReq.araddr == fpbx_pkg::ADDR_CURSOR) begin
        next_s.rData = {9'h0, s.stageNext, 6'h0, s.stageSet, 1'b0, s.rdBlk};
      end else if (rdWord != 5'h1f) begin
        next_s.rData = s.xbuf[rdWord * 4 +: 4];
      end else begin
        next_s.rResp = fpbx_pkg::RESP_SLVERR;
      end
    end

    // Register write once both halves are held
    if (s.awHeld && s.wHeld && !s.bValid) begin
      next_s.awHeld = 1'b0;
      next_s.wHeld = 1'b0;
      next_s.bValid = 1'b1;
      next_s.bResp = fpbx_pkg::RESP_OKAY;
      if (wrWord != 5'h1f) begin
        // Buffer is frozen while an operation owns it
        if (!s.busy) begin
          for (int lane = 0; lane < 4; lane++) begin
            if (s.wStrb[lane]) begin
              next_s.xbuf[wrWord * 4 + lane] = s.wData[lane * 8 +: 8];
            end
          end
        end
      end else if (s.awAddr == fpbx_pkg::ADDR_CTRL) begin
        // A command while busy is dropped; status shows busy
        if (!s.busy) begin
          next_s.param = s.wData[15:0];
          next_s.isSet = s.wData[fpbx_pkg::CTRL_SET_BIT];
          next_s.busy = 1'b1;
          next_s.done = 1'b0;
          next_s.err = 1'b0;
          next_s.idx = 6'h0;
          if (calDec[2] && s.wData[fpbx_pkg::CTRL_SET_BIT]) begin
            // Validate one incoming block before copying it in
            next_s.curSet = calDec[1:0];
            next_s.curBlk = hdrBlk;
            next_s.curFin = hdrFin;
            next_s.curLen = hdrBlkLen;
            next_s.fsm = fpbx_pkg::FPBX_COPY;
            if (hdrLen > fpbx_pkg::XCHG_LEN || hdrBlkLen > fpbx_pkg::BLOCK_DATA
                || hdrBlk >= fpbx_pkg::MAX_BLOCKS || hdrTot > fpbx_pkg::STATE_MAX
                || (!hdrFin && hdrBlkLen != fpbx_pkg::BLOCK_DATA)
                || (hdrFin && hdrLen != fpbx_pkg::XCHG_LEN)
                || (hdrBlk != 7'h0 && (hdrBlk != s.stageNext
                    || calDec[1:0] != s.stageSet))) begin
              next_s.fsm = fpbx_pkg::FPBX_IDLE;
              next_s.busy = 1'b0;
              next_s.err = 1'b1;
              next_s.stageNext = 7'h0; // Drop the broken set
            end else begin
              next_s.stageSet = calDec[1:0];
              next_s.stageLen = hdrTot;
            end
          end else if (calDec[2] && calDec[1:0] != fpbx_pkg::SET_SOFTIRON) begin
            // Return the next block of a stored state
            next_s.xbuf = '0;
            if (s.rdSet != calDec[1:0]) begin
              next_s.rdBlk = 7'h0;
            end
            next_s.rdSet = calDec[1:0];
            next_s.curSet = calDec[1:0];
            next_s.curBlk = (s.rdSet != calDec[1:0]) ? 7'h0 : s.rdBlk;
            next_s.curFin = (s.rdSet != calDec[1:0])
                            ? (s.setLen[calDec[1:0]] <= 16'(fpbx_pkg::BLOCK_DATA))
                            : (remain <= 16'(fpbx_pkg::BLOCK_DATA));
            next_s.curLen = (s.rdSet != calDec[1:0])
                            ? ((s.setLen[calDec[1:0]] > 16'(fpbx_pkg::BLOCK_DATA))
                               ? fpbx_pkg::BLOCK_DATA : s.setLen[calDec[1:0]][7:0])
                            : ((remain > 16'(fpbx_pkg::BLOCK_DATA))
                               ? fpbx_pkg::BLOCK_DATA : remain[7:0]);
            next_s.fsm = fpbx_pkg::FPBX_COPY;
          end else if (!s.wData[fpbx_pkg::CTRL_SET_BIT]
                       && s.wData[15:0] == fpbx_pkg::PARAM_LIB_VER) begin
            // Version record: length four, then four bytes
            next_s.xbuf = '0;
            next_s.xbuf[1:0] = fpbx_pkg::PARAM_LIB_VER;
            next_s.xbuf[3:2] = fpbx_pkg::VER_LEN;
            next_s.xbuf[4] = libVersion.major;
            next_s.xbuf[5] = libVersion.minor;
            next_s.xbuf[6] = libVersion.majorFix;
            next_s.xbuf[7] = libVersion.minorFix;
            next_s.busy = 1'b0;
            next_s.done = 1'b1;
          end else if (!s.wData[fpbx_pkg::CTRL_SET_BIT]
                       && s.wData[15:0] > fpbx_pkg::PARAM_VINFO_BASE
                       && s.wData[15:0] <= fpbx_pkg::PARAM_VINFO_LAST) begin
            // Present the sensor id to the lookup, fill next cycle
            next_s.infoId = 8'(s.wData[15:0] - fpbx_pkg::PARAM_VINFO_BASE);
            next_s.fsm = fpbx_pkg::FPBX_LOOK;
          end else begin
            // Unknown number, or wrong direction for a read-only or write-only one
            next_s.busy = 1'b0;
            next_s.err = 1'b1;
          end
        end
      end else if (s.awAddr != fpbx_pkg::ADDR_STATUS && s.awAddr != fpbx_pkg::ADDR_CURSOR) begin
        next_s.bResp = fpbx_pkg::RESP_SLVERR;
      end
    end

    // Library-side updates of the active state
    if (libWr.en) begin
      next_s.sets[libWr.set][libWr.addr] = libWr.data;
      next_s.setLen[libWr.set] = libWr.len;
    end

    case (s.fsm)
      fpbx_pkg::FPBX_IDLE: begin
      end
      fpbx_pkg::FPBX_COPY: begin
        // One data byte per cycle over the 64-byte payload area
        if (s.isSet) begin
          if ({2'h0, s.idx} < s.curLen) begin
            next_s.stage[pos] = s.xbuf[fpbx_pkg::OFS_DATA + 32'(s.idx)];
          end
        end else begin
          if ({2'h0, s.idx} < s.curLen) begin
            next_s.xbuf[fpbx_pkg::OFS_DATA + 32'(s.idx)] = s.sets[s.curSet][pos];
          end
          next_s.xbuf[1:0] = s.param;
          next_s.xbuf[3:2] = fpbx_pkg::XCHG_LEN;
          next_s.xbuf[fpbx_pkg::OFS_BLKINFO] = {s.curFin, s.curBlk};
          next_s.xbuf[fpbx_pkg::OFS_BLKLEN] = s.curLen;
          next_s.xbuf[fpbx_pkg::OFS_TOTLEN +: 2] = s.setLen[s.curSet];
        end
        next_s.idx = s.idx + 6'h1;
        if (s.idx == 6'h3f) begin
          next_s.fsm = fpbx_pkg::FPBX_IDLE;
          next_s.busy = 1'b0;
          next_s.done = 1'b1;
          if (s.isSet) begin
            next_s.stageNext = s.curBlk + 7'h1;
            if (s.curFin) begin
              next_s.fsm = fpbx_pkg::FPBX_COMMIT;
              next_s.busy = 1'b1;
              next_s.done = 1'b0;
            end
          end else begin
            next_s.rdBlk = s.curFin ? 7'h0 : s.curBlk + 7'h1;
          end
        end
      end
      fpbx_pkg::FPBX_COMMIT: begin
        // Whole set arrived: only now replace the active state
        next_s.sets[s.curSet] = s.stage;
        next_s.setLen[s.curSet] = s.stageLen;
        next_s.stageNext = 7'h0;
        next_s.commit = 1'b1;
        next_s.fsm = fpbx_pkg::FPBX_IDLE;
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
      end
      fpbx_pkg::FPBX_LOOK: begin
        // Record fields little endian; rates stay raw float bits
        next_s.xbuf = '0;
        next_s.xbuf[1:0] = s.param;
        next_s.xbuf[3:2] = fpbx_pkg::VINFO_LEN;
        if (infoRec.supported) begin
          next_s.xbuf[fpbx_pkg::VI_ID] = s.infoId;
          next_s.xbuf[fpbx_pkg::VI_DRV] = infoRec.driverId;
          next_s.xbuf[fpbx_pkg::VI_DRVVER] = infoRec.driverVer;
          next_s.xbuf[fpbx_pkg::VI_POWER] = infoRec.power;
          next_s.xbuf[fpbx_pkg::VI_RANGE +: 2] = infoRec.maxRange;
          next_s.xbuf[fpbx_pkg::VI_RES +: 2] = infoRec.resolution;
          next_s.xbuf[fpbx_pkg::VI_MAXRATE +: 4] = infoRec.maxRate;
          next_s.xbuf[fpbx_pkg::VI_FIFORES +: 4] = infoRec.fifoReserved;
          next_s.xbuf[fpbx_pkg::VI_FIFOMAX +: 4] = infoRec.fifoMax;
          next_s.xbuf[fpbx_pkg::VI_EVSIZE] = infoRec.eventSize;
          next_s.xbuf[fpbx_pkg::VI_MINRATE +: 4] = infoRec.minRate;
        end
        next_s.fsm = fpbx_pkg::FPBX_IDLE;
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
      end
      default: begin
        next_s.fsm = fpbx_pkg::FPBX_IDLE;
      end
    endcase
  end

  // Single register for all state; sets start empty
  always_ff @(posedge clk) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Handshake readies are combinational, payloads come from flops
  always_comb begin
    axiRsp.awready = !s.awHeld && !s.bValid;
    axiRsp.wready  = !s.wHeld && !s.bValid;
    axiRsp.bresp   = s.bResp;
    axiRsp.bvalid  = s.bValid;
    axiRsp.arready = !s.rValid;
    axiRsp.rdata   = s.rData;
    axiRsp.rresp   = s.rResp;
    axiRsp.rvalid  = s.rValid;
  end

  assign infoQueryId = s.infoId;
  assign stateRdData = s.rdOut;
  assign commitPulse = s.commit;
  assign commitSet   = s.curSet;

endmodule

// >>> logic/fpbx_pkg.sv
// Package: constants, records and bus carriers for the fusion parameter block exchange
package fpbx_pkg;

  // Register byte addresses on the AXI4-Lite bus
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_CURSOR   = 8'h08;
  localparam logic [7:0] ADDR_BUF_BASE = 8'h40;
  localparam int         BUF_WORDS     = 18;
  localparam int         BUF_BYTES     = 72;

  // Control and status fields
  localparam int CTRL_SET_BIT  = 16;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_ERR_BIT  = 2;

  // Parameter numbers
  localparam logic [15:0] PARAM_CAL_BASE   = 16'h0200;
  localparam logic [15:0] PARAM_CAL_FIRST  = 16'h0201;
  localparam logic [15:0] PARAM_CAL_LAST   = 16'h0240;
  localparam logic [7:0]  INPUT_ACCEL      = 8'h01;
  localparam logic [7:0]  INPUT_GYRO       = 8'h03;
  localparam logic [7:0]  INPUT_MAG        = 8'h05;
  localparam logic [15:0] PARAM_SOFT_IRON  = 16'h027d;
  localparam logic [15:0] PARAM_LIB_VER    = 16'h027e;
  localparam logic [15:0] PARAM_VINFO_BASE = 16'h0300;
  localparam logic [15:0] PARAM_VINFO_LAST = 16'h0395;

  // Exchange block layout
  localparam int          OFS_LEN       = 2;
  localparam int          OFS_BLKINFO   = 4;
  localparam int          OFS_BLKLEN    = 5;
  localparam int          OFS_TOTLEN    = 6;
  localparam int          OFS_DATA      = 8;
  localparam logic [7:0]  BLOCK_DATA    = 8'h40;
  localparam logic [15:0] XCHG_LEN      = 16'h0044;
  localparam logic [15:0] VER_LEN       = 16'h0004;
  localparam logic [15:0] VINFO_LEN     = 16'h001c;

  // Virtual sensor record offsets
  localparam int VI_ID = 4, VI_DRV = 5, VI_DRVVER = 6, VI_POWER = 7;
  localparam int VI_RANGE = 8, VI_RES = 10, VI_MAXRATE = 12, VI_FIFORES = 16;
  localparam int VI_FIFOMAX = 20, VI_EVSIZE = 24, VI_MINRATE = 25;

  // State storage: four sets (three sensors, soft-iron matrix)
  localparam int          STATE_BYTES = 128;
  localparam int          POS_W       = 7;
  localparam logic [6:0]  MAX_BLOCKS  = 7'h02;
  localparam logic [15:0] STATE_MAX   = 16'h0080;
  localparam logic [1:0]  SET_ACCEL   = 2'h0;
  localparam logic [1:0]  SET_GYRO    = 2'h1;
  localparam logic [1:0]  SET_MAG     = 2'h2;
  localparam logic [1:0]  SET_SOFTIRON = 2'h3;

  // AXI4-Lite answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    FPBX_IDLE   = 2'b00,
    FPBX_COPY   = 2'b01,
    FPBX_COMMIT = 2'b11,
    FPBX_LOOK   = 2'b10
  } fpbx_fsm_t;

  typedef struct packed {
    logic [7:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        rready;
  } fpbx_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } fpbx_axi_rsp_t;

  typedef struct packed {
    logic        supported;
    logic [7:0]  driverId;
    logic [7:0]  driverVer;
    logic [7:0]  power;
    logic [15:0] maxRange;
    logic [15:0] resolution;
    logic [31:0] maxRate;
    logic [31:0] fifoReserved;
    logic [31:0] fifoMax;
    logic [7:0]  eventSize;
    logic [31:0] minRate;
  } fpbx_vinfo_t;

  typedef struct packed {
    logic [7:0] major;
    logic [7:0] minor;
    logic [7:0] majorFix;
    logic [7:0] minorFix;
  } fpbx_version_t;

  typedef struct packed {
    logic             en;
    logic [1:0]       set;
    logic [POS_W-1:0] addr;
    logic [7:0]       data;
    logic [15:0]      len;
  } fpbx_lib_wr_t;

endpackage
